// ### verilog/gpio_pkg.sv
/*
 * Constants, register map and carrier types of the general-purpose I/O port
 * with change notification.
 * Assumes a 32-bit APB master and a 20 MHz system clock with async reset.
 */
// Behaviour
// - Each pin has a direction bit choosing input or driving its latch value.
// - Port register reads sampled pin levels; writes to it update the output latch.
// - Latch register reads stored latch; writes change levels on output-direction pins.
// - Read-modify-write of the latch uses stored latch bits, never pin levels.
// - An enabled sharing peripheral takes control of its pin from the port.
// - Up to 24 change inputs, each enabled separately; a change raises an interrupt.
// - A level changed in sleep with clocks stopped is flagged and interrupts once the clock restarts.
// - Every change input has its own weak pull-up on/off control.
package gpio_pkg;

    localparam int PORT_W = 16;
    localparam int CN_W = 24;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFF_DIR = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_PORT = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_LAT = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_CN_EN = 8'h0c;
    localparam logic [ADDR_W-1:0] OFF_PULLUP = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_CN_PEND = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 8'h18;
    localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h1c;

    // Interrupt status and mask layout
    localparam int IRQ_W = 2;
    localparam int IRQ_CN_BIT = 0;
    localparam int IRQ_BUSERR_BIT = 1;

    // Reset values
    localparam logic [PORT_W-1:0] DIR_RST = 16'hffff;
    localparam logic [PORT_W-1:0] LAT_RST = 16'h0000;
    localparam logic [CN_W-1:0] CN_EN_RST = 24'h000000;
    localparam logic [CN_W-1:0] PULLUP_RST = 24'h000000;
    localparam logic [IRQ_W-1:0] IRQ_RST = 2'h0;

    // APB request as seen by the slave
    typedef struct packed {
        logic sel;
        logic enable;
        logic write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } apb_req_s;

    // Drive level and enable of every port pin
    typedef struct packed {
        logic [PORT_W-1:0] out;
        logic [PORT_W-1:0] oe;
    } pin_drive_s;

    typedef enum logic {BUS_IDLE, BUS_ANSWER} bus_e;

    // Address decode used for every register
    function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] off);
        return addr == off;
    endfunction : reg_hit

endpackage : gpio_pkg

// ### verilog/gpio_pin_mux.sv
/*
 * Per-pin drive selection between the port latch and a sharing peripheral.
 * Purely combinational; the caller registers the result onto the pins.
 */
`timescale 1ns/100ps
module gpio_pin_mux #(
    parameter int WIDTH = 16
) (
    input wire logic [WIDTH-1:0] dir_in,
    input wire logic [WIDTH-1:0] latch,
    input wire logic [WIDTH-1:0] periph_en,
    input wire logic [WIDTH-1:0] periph_out,
    input wire logic [WIDTH-1:0] periph_oe,
    output logic [WIDTH-1:0] drive_out,
    output logic [WIDTH-1:0] drive_oe
);

    // Peripheral owns an enabled pin, otherwise direction bit gates the latch
    always_comb begin
        for (int i = 0; i < WIDTH; i++) begin
            if (periph_en[i]) begin
                drive_out[i] = periph_out[i];
                drive_oe[i] = periph_oe[i];
            end else begin
                drive_out[i] = latch[i];
                drive_oe[i] = ~dir_in[i];
            end
        end
    end

endmodule : gpio_pin_mux

// ### verilog/gpio_change_detect.sv
/*
 * Change-notification detector: per-input capture, compare and sticky flags.
 * Assumes inputs synchronous to clk; clears are one-cycle write-one masks.
 */
`timescale 1ns/100ps
module gpio_change_detect #(
    parameter int WIDTH = 24
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [WIDTH-1:0] cn_in,
    input wire logic [WIDTH-1:0] cn_en,
    input wire logic [WIDTH-1:0] clr,
    output logic [WIDTH-1:0] pend,
    output logic event_pulse
);

    logic [WIDTH-1:0] cap_r;
    logic [WIDTH-1:0] cap_nxt;
    logic [WIDTH-1:0] pend_r;
    logic [WIDTH-1:0] pend_nxt;
    logic evt_r;
    logic evt_nxt;
    logic [WIDTH-1:0] change;

    // Compare with the last captured level; set beats clear
    always_comb begin
        change = cn_en & (cn_in ^ cap_r);
        cap_nxt = cn_in; // level held while clock is stopped
        pend_nxt = (pend_r & ~clr) | change;
        evt_nxt = |change;
    end

    // State registers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cap_r <= '0;
            pend_r <= '0;
            evt_r <= 1'b0;
        end else begin
            cap_r <= cap_nxt;
            pend_r <= pend_nxt;
            evt_r <= evt_nxt;
        end
    end

    assign pend = pend_r;
    assign event_pulse = evt_r;

    a_change_sets: assert property (@(posedge clk) disable iff (!arst_n)
        (change != '0) |=> ((pend_r & $past(change)) == $past(change)))
        else $error("enabled change did not set its pending flag");
    a_pend_holds: assert property (@(posedge clk) disable iff (!arst_n)
        (clr == '0) |=> ((pend_r & $past(pend_r)) == $past(pend_r)))
        else $error("pending flag dropped without a clear");
    a_event_pulse: assert property (@(posedge clk) disable iff (!arst_n)
        (change != '0) |=> evt_r)
        else $error("change produced no event");

endmodule : gpio_change_detect

// ### verilog/gpio_port.sv
/*
 * General-purpose I/O port with change notification, APB register slave and
 * one level interrupt.
 * Assumes an APB master, pins and peripheral signals synchronous to CLK.
 */
// The address map and the APB slave port were chosen for this implementation.
`timescale 1ns/100ps
module gpio_port (
    input wire logic CLK,
    input wire logic ARST_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [gpio_pkg::ADDR_W-1:0] PADDR,
    input wire logic [gpio_pkg::DATA_W-1:0] PWDATA,
    output logic [gpio_pkg::DATA_W-1:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic [gpio_pkg::PORT_W-1:0] PIN_IN,
    output logic [gpio_pkg::PORT_W-1:0] PIN_OUT,
    output logic [gpio_pkg::PORT_W-1:0] PIN_OE,
    input wire logic [gpio_pkg::PORT_W-1:0] PERIPH_EN,
    input wire logic [gpio_pkg::PORT_W-1:0] PERIPH_OUT,
    input wire logic [gpio_pkg::PORT_W-1:0] PERIPH_OE,
    input wire logic [gpio_pkg::CN_W-1:0] CN_IN,
    output logic [gpio_pkg::CN_W-1:0] CN_PULLUP_EN,
    output logic IRQ
);

    gpio_pkg::apb_req_s req;
    gpio_pkg::bus_e state_r;
    gpio_pkg::bus_e state_nxt;
    gpio_pkg::pin_drive_s drive;

    logic [gpio_pkg::DATA_W-1:0] prdata_r;
    logic [gpio_pkg::DATA_W-1:0] prdata_nxt;
    logic pready_r;
    logic pready_nxt;
    logic pslverr_r;
    logic pslverr_nxt;

    logic [gpio_pkg::PORT_W-1:0] dir_r;
    logic [gpio_pkg::PORT_W-1:0] dir_nxt;
    logic [gpio_pkg::PORT_W-1:0] lat_r;
    logic [gpio_pkg::PORT_W-1:0] lat_nxt;
    logic [gpio_pkg::PORT_W-1:0] pin_smp_r;
    logic [gpio_pkg::CN_W-1:0] cn_en_r;
    logic [gpio_pkg::CN_W-1:0] cn_en_nxt;
    logic [gpio_pkg::CN_W-1:0] pull_r;
    logic [gpio_pkg::CN_W-1:0] pull_nxt;
    logic [gpio_pkg::IRQ_W-1:0] stat_r;
    logic [gpio_pkg::IRQ_W-1:0] stat_nxt;
    logic [gpio_pkg::IRQ_W-1:0] mask_r;
    logic [gpio_pkg::IRQ_W-1:0] mask_nxt;
    logic [gpio_pkg::IRQ_W-1:0] stat_set;
    logic [gpio_pkg::IRQ_W-1:0] stat_clr;
    logic irq_r;
    logic irq_nxt;
    logic [gpio_pkg::PORT_W-1:0] pin_out_r;
    logic [gpio_pkg::PORT_W-1:0] pin_oe_r;

    logic start;
    logic access;
    logic wr;
    logic mapped;
    logic [gpio_pkg::CN_W-1:0] cn_clr;
    logic [gpio_pkg::CN_W-1:0] cn_pend;
    logic cn_event;

    // Bundle the APB request
    assign req = '{sel: PSEL, enable: PENABLE, write: PWRITE, addr: PADDR, wdata: PWDATA};

    // Decode of the current address
    always_comb begin
        mapped = gpio_pkg::reg_hit(req.addr, gpio_pkg::OFF_DIR)
              || gpio_pkg::reg_hit(req.addr, gpio_pkg::OFF_PORT)
              || gpio_pkg::reg_hit(req.addr, gpio_pkg::OFF_LAT)
              || gpio_pkg::reg_hit(req.addr, gpio_pkg::OFF_CN_EN)
              || gpio_pkg::reg_hit(req.addr, gpio_pkg::OFF_PULLUP)
              || gpio_pkg::reg_hit(req.addr, gpio_pkg::OFF_CN_PEND)
              || gpio_pkg::reg_hit(req.addr, gpio_pkg::OFF_IRQ_STAT)
              || gpio_pkg::reg_hit(req.addr, gpio_pkg::OFF_IRQ_MASK);
    end

    // First access cycle starts an answer; completing edge commits the write
    assign start = req.sel && req.enable && (state_r == gpio_pkg::BUS_IDLE);
    assign access = req.sel && req.enable && pready_r;
    assign wr = access && req.write && mapped;

    // Bus answer: one wait state, read data and error registered
    always_comb begin
        state_nxt = state_r;
        prdata_nxt = '0;
        pslverr_nxt = 1'b0;
        case (state_r)
            gpio_pkg::BUS_IDLE: begin
                if (start) begin
                    state_nxt = gpio_pkg::BUS_ANSWER;
                    pslverr_nxt = !mapped;
                    if (!req.write) begin
                        if (gpio_pkg::reg_hit(req.addr, gpio_pkg::OFF_DIR)) begin
                            prdata_nxt = {16'h0000, dir_r};
                        end else if (gpio_pkg::reg_hit(req.addr, gpio_pkg::OFF_PORT)) begin
                            prdata_nxt = {16'h0000, pin_smp_r};
                        end else if (gpio_pkg::reg_hit(req.addr, gpio_pkg::OFF_LAT)) begin
                            prdata_nxt = {16'h0000, lat_r};
                        end else if (gpio_pkg::reg_hit(req.addr, gpio_pkg::OFF_CN_EN)) begin
                            prdata_nxt = {8'h00, cn_en_r};
                        end else if (gpio_pkg::reg_hit(req.addr, gpio_pkg::OFF_PULLUP)) begin
                            prdata_nxt = {8'h00, pull_r};
                        end else if (gpio_pkg::reg_hit(req.addr, gpio_pkg::OFF_CN_PEND)) begin
                            prdata_nxt = {8'h00, cn_pend};
                        end else if (gpio_pkg::reg_hit(req.addr, gpio_pkg::OFF_IRQ_STAT)) begin
                            prdata_nxt = {30'h0, stat_r};
                        end else if (gpio_pkg::reg_hit(req.addr, gpio_pkg::OFF_IRQ_MASK)) begin
                            prdata_nxt = {30'h0, mask_r};
                        end else begin
                            prdata_nxt = '0;
                        end
                    end
                end
            end
            gpio_pkg::BUS_ANSWER: begin
                state_nxt = gpio_pkg::BUS_IDLE;
            end
            default: begin
                state_nxt = gpio_pkg::BUS_IDLE;
            end
        endcase
        pready_nxt = (state_nxt == gpio_pkg::BUS_ANSWER);
    end

    // Bus registers
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            state_r <= gpio_pkg::BUS_IDLE;
            prdata_r <= '0;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            prdata_r <= prdata_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    // Software registers; port and latch writes both land in the latch
    always_comb begin
        dir_nxt = dir_r;
        lat_nxt = lat_r;
        cn_en_nxt = cn_en_r;
        pull_nxt = pull_r;
        mask_nxt = mask_r;
        if (wr) begin
            if (gpio_pkg::reg_hit(req.addr, gpio_pkg::OFF_DIR)) begin
                dir_nxt = req.wdata[gpio_pkg::PORT_W-1:0];
            end
            if (gpio_pkg::reg_hit(req.addr, gpio_pkg::OFF_PORT)) begin
                lat_nxt = req.wdata[gpio_pkg::PORT_W-1:0];
            end
            if (gpio_pkg::reg_hit(req.addr, gpio_pkg::OFF_LAT)) begin
                lat_nxt = req.wdata[gpio_pkg::PORT_W-1:0];
            end
            if (gpio_pkg::reg_hit(req.addr, gpio_pkg::OFF_CN_EN)) begin
                cn_en_nxt = req.wdata[gpio_pkg::CN_W-1:0];
            end
            if (gpio_pkg::reg_hit(req.addr, gpio_pkg::OFF_PULLUP)) begin
                pull_nxt = req.wdata[gpio_pkg::CN_W-1:0];
            end
            if (gpio_pkg::reg_hit(req.addr, gpio_pkg::OFF_IRQ_MASK)) begin
                mask_nxt = req.wdata[gpio_pkg::IRQ_W-1:0];
            end
        end
    end

    // Write-one-to-clear masks for pending flags and status
    always_comb begin
        cn_clr = '0;
        stat_clr = '0;
        if (wr && gpio_pkg::reg_hit(req.addr, gpio_pkg::OFF_CN_PEND)) begin
            cn_clr = req.wdata[gpio_pkg::CN_W-1:0];
        end
        if (wr && gpio_pkg::reg_hit(req.addr, gpio_pkg::OFF_IRQ_STAT)) begin
            stat_clr = req.wdata[gpio_pkg::IRQ_W-1:0];
        end
    end

    // Sticky status: a new event wins over a clear in the same cycle
    always_comb begin
        stat_set = '0;
        stat_set[gpio_pkg::IRQ_CN_BIT] = cn_event;
        stat_set[gpio_pkg::IRQ_BUSERR_BIT] = access && !mapped;
        stat_nxt = (stat_r & ~stat_clr) | stat_set;
        irq_nxt = |(stat_r & mask_r);
    end

    // Register and status flops
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            dir_r <= gpio_pkg::DIR_RST;
            lat_r <= gpio_pkg::LAT_RST;
            cn_en_r <= gpio_pkg::CN_EN_RST;
            pull_r <= gpio_pkg::PULLUP_RST;
            mask_r <= gpio_pkg::IRQ_RST;
            stat_r <= gpio_pkg::IRQ_RST;
            irq_r <= 1'b0;
        end else begin
            dir_r <= dir_nxt;
            lat_r <= lat_nxt;
            cn_en_r <= cn_en_nxt;
            pull_r <= pull_nxt;
            mask_r <= mask_nxt;
            stat_r <= stat_nxt;
            irq_r <= irq_nxt;
        end
    end

    // Pin drive selection
    gpio_pin_mux #(
        .WIDTH(gpio_pkg::PORT_W)
    ) u_mux (
        .dir_in(dir_r),
        .latch(lat_r),
        .periph_en(PERIPH_EN),
        .periph_out(PERIPH_OUT),
        .periph_oe(PERIPH_OE),
        .drive_out(drive.out),
        .drive_oe(drive.oe)
    );

    // Change notification on the dedicated inputs
    gpio_change_detect #(
        .WIDTH(gpio_pkg::CN_W)
    ) u_cn (
        .clk(CLK),
        .arst_n(ARST_N),
        .cn_in(CN_IN),
        .cn_en(cn_en_r),
        .clr(cn_clr),
        .pend(cn_pend),
        .event_pulse(cn_event)
    );

    // Pin sampling and registered pin drive
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            pin_smp_r <= '0;
            pin_out_r <= '0;
            pin_oe_r <= '0;
        end else begin
            pin_smp_r <= PIN_IN;
            pin_out_r <= drive.out;
            pin_oe_r <= drive.oe;
        end
    end

    // Outputs
    assign PRDATA = prdata_r;
    assign PREADY = pready_r;
    assign PSLVERR = pslverr_r;
    assign PIN_OUT = pin_out_r;
    assign PIN_OE = pin_oe_r;
    assign CN_PULLUP_EN = pull_r;
    assign IRQ = irq_r;

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!ARST_N);

    a_port_write_latch: assert property (wr && gpio_pkg::reg_hit(req.addr, gpio_pkg::OFF_PORT)
        |=> lat_r == $past(req.wdata[15:0]))
        else $error("port write did not reach the latch");
    a_port_read_pins: assert property (start && !req.write && gpio_pkg::reg_hit(req.addr, gpio_pkg::OFF_PORT)
        |=> PRDATA == {16'h0000, $past(pin_smp_r)} && PREADY)
        else $error("port read did not return sampled pins");
    a_latch_write: assert property (wr && gpio_pkg::reg_hit(req.addr, gpio_pkg::OFF_LAT)
        |=> lat_r == $past(req.wdata[15:0]) ##1 (PIN_OUT & ~$past(PERIPH_EN)) == (lat_r & ~$past(PERIPH_EN)))
        else $error("latch write did not reach the pins");
    a_latch_read_rmw: assert property (start && !req.write && gpio_pkg::reg_hit(req.addr, gpio_pkg::OFF_LAT)
        |=> PRDATA == {16'h0000, $past(lat_r)})
        else $error("latch read did not return stored bits");
    a_dir_drive: assert property ((PERIPH_EN == '0)
        |=> PIN_OE == ~$past(dir_r) && PIN_OUT == $past(lat_r))
        else $error("direction or latch not driven onto pins");
    a_periph_owns: assert property ((PERIPH_EN == 16'hffff)
        |=> PIN_OE == $past(PERIPH_OE) && PIN_OUT == $past(PERIPH_OUT))
        else $error("peripheral did not take over its pins");
    a_pullup_write: assert property (wr && gpio_pkg::reg_hit(req.addr, gpio_pkg::OFF_PULLUP)
        |=> CN_PULLUP_EN == $past(req.wdata[23:0]))
        else $error("pull-up control not applied");
    a_irq_level: assert property ((cn_event && mask_r[0])
        |-> ##2 IRQ)
        else $error("unmasked change did not raise the interrupt");

    c_port_read: cover property (start && !req.write && gpio_pkg::reg_hit(req.addr, gpio_pkg::OFF_PORT));
    c_cn_irq: cover property (cn_event ##[1:4] IRQ);
    c_bus_error: cover property (access && !mapped);

endmodule : gpio_port

// ### dv/pin_world.sv
/*
 * Model of the board around the port: resolves each pin from the port drive
 * and an external source, and each change line from its driver or pull-up.
 * Assumes the bench sets the external values after rising clock edges.
 */
`timescale 1ns/100ps
module pin_world (
    input wire logic [gpio_pkg::PORT_W-1:0] pin_out,
    input wire logic [gpio_pkg::PORT_W-1:0] pin_oe,
    input wire logic [gpio_pkg::PORT_W-1:0] ext_val,
    input wire logic [gpio_pkg::CN_W-1:0] cn_val,
    input wire logic [gpio_pkg::CN_W-1:0] cn_drv,
    input wire logic [gpio_pkg::CN_W-1:0] pullup_en,
    output logic [gpio_pkg::PORT_W-1:0] pin_in,
    output logic [gpio_pkg::CN_W-1:0] cn_in
);
    // Port drive wins where enabled, the outside source elsewhere
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_val);
    // Released line: pull-up gives one, a floating line shows the inverse of its last level
    assign cn_in = (cn_drv & cn_val) | (~cn_drv & (pullup_en | ~cn_val));
endmodule : pin_world

// ### dv/tb_top.sv
/*
 * Self-checking bench for the I/O port: APB register tasks, pin and change
 * notification scenarios. Assumes the board model and the design package.
 */
`timescale 1ns/100ps
module tb_top;
    logic CLK = 1'b0;
    logic ARST_N = 1'b0;
    logic clk_run = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, irq, err;
    logic [15:0] pin_in, pin_out, pin_oe, ext_val = 16'h3c3c;
    logic [15:0] per_en = 16'h0, per_out = 16'h0, per_oe = 16'h0;
    logic [23:0] cn_in, cn_pu, cn_val = 24'h0, cn_drv = 24'hffffff;
    int failures = 0;
    int cmp_count = 0;

    // Clock, gated while the device sleeps
    always #25 CLK = clk_run ? ~CLK : CLK;

    gpio_port dut (.CLK(CLK), .ARST_N(ARST_N), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE(pin_oe), .PERIPH_EN(per_en),
        .PERIPH_OUT(per_out), .PERIPH_OE(per_oe), .CN_IN(cn_in), .CN_PULLUP_EN(cn_pu), .IRQ(irq));

    pin_world board (.pin_out(pin_out), .pin_oe(pin_oe), .ext_val(ext_val), .cn_val(cn_val),
        .cn_drv(cn_drv), .pullup_en(cn_pu), .pin_in(pin_in), .cn_in(cn_in));

    task automatic give_verdict;
        $display("Checks made %0d, mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : give_verdict

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            $display("Error %s expected %h seen %h", name, exp, got);
            failures++;
        end
    endtask : chk

    // One APB transfer; ready, data and error are taken at the rising edge that completes it
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rdv, output logic e);
        @(posedge CLK);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge CLK);
        penable <= 1'b1;
        do begin
            @(posedge CLK);
        end while (pready !== 1'b1);
        rdv = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr32(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, rd, err);
    endtask : wr32

    task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, rd, err);
        chk(name, exp, rd);
    endtask : rdchk

    // Let a pin or flag settle the fixed edges the design needs, then look mid-cycle
    task automatic settle(input int n);
        repeat (n) @(posedge CLK);
        @(negedge CLK);
    endtask : settle

    initial begin
        repeat (20000) @(posedge CLK);
        $display("Error watchdog expired");
        failures++;
        give_verdict();
    end

    initial begin
        repeat (16) @(posedge CLK);
        ARST_N <= 1'b1;
        // Reset values
        rdchk("dir_rst", gpio_pkg::OFF_DIR, 32'h0000ffff);
        rdchk("lat_rst", gpio_pkg::OFF_LAT, 32'h0);
        rdchk("cnen_rst", gpio_pkg::OFF_CN_EN, 32'h0);
        rdchk("pu_rst", gpio_pkg::OFF_PULLUP, 32'h0);
        rdchk("mask_rst", gpio_pkg::OFF_IRQ_MASK, 32'h0);
        chk("oe_rst", 32'h0, {16'h0, pin_oe});
        $display("Test reset done");
        // Direction and latch drive; port reads the pins
        wr32(gpio_pkg::OFF_DIR, 32'h0000ff00);
        wr32(gpio_pkg::OFF_LAT, 32'h0000a5a5);
        settle(2);
        chk("pin_oe", 32'h00ff, {16'h0, pin_oe});
        chk("pin_out", 32'h00a5, {16'h0, pin_out & pin_oe});
        rdchk("port_pins", gpio_pkg::OFF_PORT, 32'h00003ca5);
        rdchk("lat_read", gpio_pkg::OFF_LAT, 32'h0000a5a5);
        wr32(gpio_pkg::OFF_PORT, 32'h00001234);
        rdchk("port_wr_lat", gpio_pkg::OFF_LAT, 32'h00001234);
        apb(1'b0, gpio_pkg::OFF_LAT, 32'h0, rd, err);
        wr32(gpio_pkg::OFF_LAT, rd | 32'h00000100);
        rdchk("lat_rmw", gpio_pkg::OFF_LAT, 32'h00001334);
        settle(2);
        chk("pin_out_rmw", 32'h0034, {16'h0, pin_out & pin_oe});
        $display("Test port done");
        // Peripheral takes over low nibble
        @(posedge CLK);
        per_en <= 16'h000f;
        per_out <= 16'h000a;
        per_oe <= 16'h0005;
        settle(2);
        chk("per_oe", 32'h00f5, {16'h0, pin_oe});
        chk("per_out", 32'h000a, {28'h0, pin_out[3:0]});
        $display("Test peripheral done");
        // Every change input in turn, with the interrupt unmasked
        wr32(gpio_pkg::OFF_CN_EN, 32'h00ffffff);
        wr32(gpio_pkg::OFF_IRQ_MASK, 32'h1);
        for (int i = 0; i < gpio_pkg::CN_W; i++) begin
            @(posedge CLK);
            cn_val[i] <= ~cn_val[i];
            settle(3);
            chk("irq_set", 32'h1, {31'h0, irq});
            rdchk("pend_one", gpio_pkg::OFF_CN_PEND, 32'h1 << i);
            wr32(gpio_pkg::OFF_CN_PEND, 32'h1 << i);
            wr32(gpio_pkg::OFF_IRQ_STAT, 32'h1);
            settle(2);
            chk("irq_clr", 32'h0, {31'h0, irq});
        end
        rdchk("pend_clear", gpio_pkg::OFF_CN_PEND, 32'h0);
        $display("Test change notify done");
        // Disabled input gives no flag; masked event leaves the line low
        wr32(gpio_pkg::OFF_CN_EN, 32'h00fffffe);
        wr32(gpio_pkg::OFF_IRQ_MASK, 32'h0);
        @(posedge CLK);
        cn_val <= cn_val ^ 24'h000003;
        settle(4);
        chk("irq_masked", 32'h0, {31'h0, irq});
        rdchk("pend_dis", gpio_pkg::OFF_CN_PEND, 32'h2);
        rdchk("stat_ev", gpio_pkg::OFF_IRQ_STAT, 32'h1);
        wr32(gpio_pkg::OFF_CN_PEND, 32'h2);
        wr32(gpio_pkg::OFF_IRQ_STAT, 32'h1);
        $display("Test mask done");
        // Sleep: change while the clock is stopped
        wr32(gpio_pkg::OFF_IRQ_MASK, 32'h1);
        @(negedge CLK);
        clk_run = 1'b0;
        #500 cn_val[5] = ~cn_val[5];
        #500 clk_run = 1'b1;
        settle(4);
        chk("irq_sleep", 32'h1, {31'h0, irq});
        rdchk("pend_sleep", gpio_pkg::OFF_CN_PEND, 32'h20);
        wr32(gpio_pkg::OFF_CN_PEND, 32'h20);
        wr32(gpio_pkg::OFF_IRQ_STAT, 32'h1);
        $display("Test sleep done");
        // Pull-up holds a released high line high; without it the line falls and is flagged
        wr32(gpio_pkg::OFF_PULLUP, 32'h00000010);
        settle(1);
        chk("pullup_pin", 32'h10, {8'h0, cn_pu});
        @(posedge CLK);
        cn_drv[4] <= 1'b0;
        settle(4);
        rdchk("pend_pullup", gpio_pkg::OFF_CN_PEND, 32'h0);
        wr32(gpio_pkg::OFF_PULLUP, 32'h00000000);
        settle(4);
        rdchk("pend_float", gpio_pkg::OFF_CN_PEND, 32'h10);
        $display("Test pull-up done");
        // Unmapped address is refused and flagged
        wr32(gpio_pkg::OFF_IRQ_STAT, 32'h3);
        wr32(gpio_pkg::OFF_IRQ_MASK, 32'h2);
        apb(1'b0, 8'h40, 32'h0, rd, err);
        chk("slverr", 32'h1, {31'h0, err});
        chk("bad_data", 32'h0, rd);
        settle(3);
        chk("irq_buserr", 32'h1, {31'h0, irq});
        rdchk("stat_buserr", gpio_pkg::OFF_IRQ_STAT, 32'h2);
        $display("Test unmapped done");
        give_verdict();
    end
endmodule : tb_top
